// ---- design/qpot_pkg.sv ----
/*
 * qpot_pkg: constants shared by the quad pot command frame decoder.
 * Assumes a 40 MHz system clock; the bus clock arrives from the master.
 */
package qpot_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_POTS = 4;
	localparam int NUM_BANKS = 4;
	localparam int POS_W = 6;

	// ----------------------------------------------------------------
	// frame fields
	// ----------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
	localparam logic [3:0] OP_READ_WIPER = 4'h9;
	localparam logic [3:0] OP_READ_STORED = 4'hb;
	localparam logic [3:0] OP_WRITE_STORED = 4'hc;
	localparam logic [3:0] OP_XFER_TO_WIPER = 4'hd;
	localparam logic [3:0] OP_SAVE_WIPER = 4'he;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam logic [3:0] OP_GLOBAL_RECALL = 4'h1;
	localparam logic [3:0] OP_GLOBAL_SAVE = 4'h8;
	localparam logic [1:0] ZERO_PAIR = 2'h0;
	localparam logic [POS_W-1:0] POS_MAX = 6'h3f;
	localparam logic [POS_W-1:0] POS_MIN = 6'h00;
	localparam logic [POS_W-1:0] STORED_INIT = 6'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 40000;
	localparam int NV_WRITE_MS = 10;
	// longest time; 10 ms at 40 MHz is a whole cycle count
	localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_KHZ;
	localparam int NV_CNT_W = 19;

	typedef enum logic [2:0] {
		QPOT_IDLE, QPOT_ADDR, QPOT_INSTR, QPOT_WDATA, QPOT_RDATA, QPOT_STEP, QPOT_WAIT
	} qpot_state_t;
endpackage

// ---- design/qpot_frame_decoder.sv ----
/*
 * qpot_frame_decoder: slave end of the 2-wire bus of a quad digital pot,
 * with four wiper position registers and sixteen stored setting registers.
 * Assumes an open-drain bus resolved outside; scl_clk_i is the bus clock.
 */
// Behaviour
// - frame is start, type code, address; match acks unless a nonvolatile write is running
// - write wiper: opcode, data byte, acks, stop
// - read stored: two zeros, six bits out
// - write stored: data byte, nonvolatile write after stop
// - transfer stored value to wiper after stop
// - save wiper into stored register after stop
// - step: direction bits without acks until stop
// - each sampled direction bit moves wiper one, saturating at both ends
// - global recall loads all wipers from bank
// - global save stores all wipers into bank
// - data high increments, data low decrements
// - nonvolatile write completes within 10 ms
// - power-up loads wipers from bank zero
`timescale 1ns/100ps
`default_nettype none

module qpot_frame_decoder #(
	parameter logic [3:0] TYPE_CODE = 4'ha, // arbitrary value
	parameter int NV_CYCLES = qpot_pkg::NV_WRITE_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_clk_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [3:0] chip_address_i,
	output logic [23:0] wiper_position_o,
	output logic nv_busy_o
);
	localparam int NP = qpot_pkg::NUM_POTS;
	localparam int NB = qpot_pkg::NUM_BANKS;
	localparam int PW = qpot_pkg::POS_W;

	// ----------------------------------------------------------------
	// link domain: sample data on the rising bus clock
	// ----------------------------------------------------------------
	logic bit_cap_reg;
	always_ff @(posedge scl_clk_i) begin
		bit_cap_reg <= sda_i;
	end

	// ----------------------------------------------------------------
	// system domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic [1:0] bit_sy;
		logic [7:0] adr_sy;
		logic scl_d;
		logic sda_d;
		qpot_pkg::qpot_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] instr;
		logic pend;
		logic oe;
		logic busy;
		logic [qpot_pkg::NV_CNT_W-1:0] nv_cnt;
		logic [NP-1:0][PW-1:0] wiper;
		logic [NP-1:0][NB-1:0][PW-1:0] stored;
	} qpot_regs_t;

	qpot_regs_t state_reg, state_next;

	function automatic logic [PW-1:0] step_pos(input logic [PW-1:0] pos, input logic up);
		if (up)
			step_pos = (pos == qpot_pkg::POS_MAX) ? pos : pos + 6'h01;
		else
			step_pos = (pos == qpot_pkg::POS_MIN) ? pos : pos - 6'h01;
	endfunction

	function automatic logic op_valid(input logic [7:0] ins);
		unique case (ins[7:4])
			qpot_pkg::OP_WRITE_WIPER, qpot_pkg::OP_READ_WIPER, qpot_pkg::OP_STEP:
				op_valid = (ins[3:2] == qpot_pkg::ZERO_PAIR);
			qpot_pkg::OP_GLOBAL_RECALL, qpot_pkg::OP_GLOBAL_SAVE:
				op_valid = (ins[1:0] == qpot_pkg::ZERO_PAIR);
			qpot_pkg::OP_READ_STORED, qpot_pkg::OP_WRITE_STORED,
			qpot_pkg::OP_XFER_TO_WIPER, qpot_pkg::OP_SAVE_WIPER:
				op_valid = 1'b1;
			default:
				op_valid = 1'b0;
		endcase
	endfunction

	logic rise, fall, start_ev, stop_ev;
	logic [1:0] pot, bank;

	always_comb begin
		state_next = state_reg;
		rise = state_reg.scl_sy[1] & ~state_reg.scl_d;
		fall = ~state_reg.scl_sy[1] & state_reg.scl_d;
		start_ev = state_reg.scl_sy[1] & state_reg.scl_d & state_reg.sda_d & ~state_reg.sda_sy[1];
		stop_ev = state_reg.scl_sy[1] & state_reg.scl_d & ~state_reg.sda_d & state_reg.sda_sy[1];
		pot = state_reg.instr[1:0];
		bank = state_reg.instr[3:2];

		// second stage is the only reader of each first stage
		state_next.scl_sy = {state_reg.scl_sy[0], scl_clk_i};
		state_next.sda_sy = {state_reg.sda_sy[0], sda_i};
		state_next.bit_sy = {state_reg.bit_sy[0], bit_cap_reg};
		state_next.adr_sy = {state_reg.adr_sy[3:0], chip_address_i};
		state_next.scl_d = state_reg.scl_sy[1];
		state_next.sda_d = state_reg.sda_sy[1];

		// ----------------------------------------------------------------
		// nonvolatile write timer
		// ----------------------------------------------------------------
		if (state_reg.busy) begin
			if (state_reg.nv_cnt == qpot_pkg::NV_CNT_W'(NV_CYCLES - 1))
				state_next.busy = 1'b0;
			state_next.nv_cnt = state_reg.nv_cnt + 1'b1;
		end

		if (start_ev) begin
			state_next.st = qpot_pkg::QPOT_ADDR;
			state_next.cnt = '0;
			state_next.oe = 1'b0;
			state_next.pend = 1'b0;
		end else if (stop_ev) begin
			state_next.st = qpot_pkg::QPOT_IDLE;
			state_next.oe = 1'b0;
			state_next.pend = 1'b0;
			if (state_reg.pend && state_reg.st == qpot_pkg::QPOT_WAIT) begin
				unique case (state_reg.instr[7:4])
					qpot_pkg::OP_XFER_TO_WIPER:
						state_next.wiper[pot] = state_reg.stored[pot][bank];
					qpot_pkg::OP_SAVE_WIPER: begin
						state_next.stored[pot][bank] = state_reg.wiper[pot];
						state_next.busy = 1'b1;
					end
					qpot_pkg::OP_WRITE_STORED: begin
						state_next.stored[pot][bank] = state_reg.sh[PW-1:0];
						state_next.busy = 1'b1;
					end
					qpot_pkg::OP_GLOBAL_RECALL:
						for (int p = 0; p < NP; p++)
							state_next.wiper[p] = state_reg.stored[p][bank];
					qpot_pkg::OP_GLOBAL_SAVE: begin
						for (int p = 0; p < NP; p++)
							state_next.stored[p][bank] = state_reg.wiper[p];
						state_next.busy = 1'b1;
					end
					default: ;
				endcase
				state_next.nv_cnt = '0;
			end
		end else begin
			// ----------------------------------------------------------------
			// frame sequencing
			// ----------------------------------------------------------------
			unique case (state_reg.st)
				qpot_pkg::QPOT_ADDR, qpot_pkg::QPOT_INSTR, qpot_pkg::QPOT_WDATA: begin
					if (rise && state_reg.cnt < qpot_pkg::BITS_PER_BYTE) begin
						state_next.sh = {state_reg.sh[6:0], state_reg.bit_sy[1]};
						state_next.cnt = state_reg.cnt + 4'h1;
					end else if (fall && state_reg.cnt == qpot_pkg::BITS_PER_BYTE) begin
						state_next.cnt = qpot_pkg::ACK_SLOT;
						if (state_reg.st == qpot_pkg::QPOT_ADDR)
							state_next.oe = (state_reg.sh == {TYPE_CODE, state_reg.adr_sy[7:4]})
								&& !state_reg.busy;
						else if (state_reg.st == qpot_pkg::QPOT_INSTR) begin
							state_next.oe = op_valid(state_reg.sh);
							state_next.instr = state_reg.sh;
						end else
							state_next.oe = 1'b1;
					end else if (fall && state_reg.cnt == qpot_pkg::ACK_SLOT) begin
						state_next.cnt = '0;
						state_next.oe = 1'b0;
						if (!state_reg.oe)
							state_next.st = qpot_pkg::QPOT_IDLE;
						else if (state_reg.st == qpot_pkg::QPOT_ADDR)
							state_next.st = qpot_pkg::QPOT_INSTR;
						else if (state_reg.st == qpot_pkg::QPOT_WDATA) begin
							if (state_reg.instr[7:4] == qpot_pkg::OP_WRITE_WIPER)
								state_next.wiper[pot] = state_reg.sh[PW-1:0];
							state_next.pend = 1'b1;
							state_next.st = qpot_pkg::QPOT_WAIT;
						end else begin
							unique case (state_reg.instr[7:4])
								qpot_pkg::OP_WRITE_WIPER, qpot_pkg::OP_WRITE_STORED:
									state_next.st = qpot_pkg::QPOT_WDATA;
								qpot_pkg::OP_READ_STORED, qpot_pkg::OP_READ_WIPER: begin
									state_next.st = qpot_pkg::QPOT_RDATA;
									state_next.sh = {qpot_pkg::ZERO_PAIR,
										(state_reg.instr[7:4] == qpot_pkg::OP_READ_WIPER)
										? state_reg.wiper[pot] : state_reg.stored[pot][bank]};
									state_next.oe = 1'b1; // leading zero pulls low
								end
								qpot_pkg::OP_STEP:
									state_next.st = qpot_pkg::QPOT_STEP;
								default: begin
									state_next.st = qpot_pkg::QPOT_WAIT;
									state_next.pend = 1'b1;
								end
							endcase
						end
					end
				end
				qpot_pkg::QPOT_RDATA: begin
					if (rise)
						state_next.cnt = state_reg.cnt + 4'h1;
					else if (fall && state_reg.cnt == qpot_pkg::BITS_PER_BYTE) begin
						state_next.oe = 1'b0; // master acknowledge slot
						state_next.st = qpot_pkg::QPOT_WAIT;
					end else if (fall && state_reg.cnt != '0) begin
						state_next.sh = {state_reg.sh[6:0], 1'b0};
						state_next.oe = ~state_reg.sh[6];
					end
				end
				// commit on the falling clock: a stop ends the high phase first,
				// so its rising clock with data low is never taken as a decrement
				qpot_pkg::QPOT_STEP:
					if (fall)
						state_next.wiper[pot] = step_pos(state_reg.wiper[pot],
							state_reg.bit_sy[1]);
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
			state_reg.st <= qpot_pkg::QPOT_IDLE;
			// the bus idles high; starting the edge detectors there avoids a false edge
			state_reg.scl_sy <= '1;
			state_reg.sda_sy <= '1;
			state_reg.scl_d <= 1'b1;
			state_reg.sda_d <= 1'b1;
			for (int p = 0; p < NP; p++) begin
				// stored contents model the power-up image
				for (int b = 0; b < NB; b++)
					state_reg.stored[p][b] <= qpot_pkg::STORED_INIT;
				state_reg.wiper[p] <= qpot_pkg::STORED_INIT;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign sda_o = 1'b0;
	assign sda_oe_o = state_reg.oe;
	assign wiper_position_o = state_reg.wiper;
	assign nv_busy_o = state_reg.busy;
endmodule // qpot_frame_decoder

`default_nettype wire

// ---- verif/qpot_frame_decoder_chk.sv ----
/* qpot_frame_decoder_chk: port-level assertions for the pot frame decoder.
   Assumes only the decoder's ports; attached by the bind at the foot. */
`timescale 1ns/100ps
`default_nettype none
module qpot_frame_decoder_chk #(
	parameter int NV_CYCLES = 400000
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_clk_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [3:0] chip_address_i,
	input wire logic [23:0] wiper_position_o,
	input wire logic nv_busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	int busy_cnt;
	always_ff @(posedge clk_i) begin
		busy_cnt <= (sys_rst_i || !nv_busy_o) ? 0 : busy_cnt + 1;
	end
	// an ack or read bit must keep the line driven for at least eight clk_i cycles
	sequence s_drive_hold;
		sda_oe_o [*8];
	endsequence
	a_drain_only: assert property (sda_o == 1'b0) else $error("data output not low");
	a_reset_clear: assert property (disable iff (1'b0) sys_rst_i |=>
		!sda_oe_o && !nv_busy_o && wiper_position_o == 24'h0) else $error("reset state wrong");
	a_busy_no_ack: assert property (nv_busy_o |-> !sda_oe_o) else $error("ack while busy");
	a_busy_bound: assert property (busy_cnt <= NV_CYCLES) else $error("write too long");
	a_drive_holds: assert property ($rose(sda_oe_o) |-> s_drive_hold) else $error("short ack");
	a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
		else $error("data driven change while scl high");
	a_busy_at_stop: assert property ($rose(nv_busy_o) |-> scl_clk_i && sda_i)
		else $error("write began outside idle");
	a_wiper_busy: assert property (nv_busy_o && $past(nv_busy_o) |-> $stable(wiper_position_o))
		else $error("wiper moved during write");
endmodule // qpot_frame_decoder_chk
bind qpot_frame_decoder qpot_frame_decoder_chk #(.NV_CYCLES(NV_CYCLES)) u_chk (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .chip_address_i(chip_address_i), .wiper_position_o(wiper_position_o),
	.nv_busy_o(nv_busy_o));
`default_nettype wire

// ---- verif/qpot_host_model.sv ----
/* qpot_host_model: bus master that issues command frames.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/100ps
`default_nettype none
module qpot_host_model (
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	// quarter bit time, unrelated to the system clock; scl stands high between frames
	localparam time Q = 103;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic start();
		#Q sda_o = 1'b0;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_o = 1'b1;
		#(4*Q);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		#Q scl_o = 1'b1;
		#Q r = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic send(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic recv(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, v[i]);
		bit_io(1'b1, r);
	endtask
endmodule // qpot_host_model
`default_nettype wire

// ---- verif/tb.sv ----
/* tb: self-checking bench for the pot frame decoder against a queue-free model.
   Assumes the host model and the checker bound to the decoder. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int NVC = 400;
	localparam logic [3:0] TYPE = 4'ha; // arbitrary value
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] addr = 4'h0;
	logic scl, m_sda, sda, sda_o, sda_oe, busy, a;
	logic [7:0] v;
	logic [23:0] wp_o;
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 41;
	int wp[4];
	int st[4][4];
	// open drain: the device pulls low only while enabled and driving zero
	assign sda = m_sda & (~sda_oe | sda_o);
	always #12.5 clk_i = ~clk_i;
	qpot_frame_decoder #(.TYPE_CODE(TYPE), .NV_CYCLES(NVC)) u_qpot_frame_decoder (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .scl_clk_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.chip_address_i(addr), .wiper_position_o(wp_o), .nv_busy_o(busy));
	qpot_host_model u_qpot_host_model (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
	task automatic end_sim();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error %0t %s", $time, m);
		end
	endtask
	task automatic chk_wp();
		for (int p = 0; p < 4; p++)
			chk(wp_o[6*p +: 6] === 6'(wp[p]), "wiper mismatch");
	endtask
	// only commands that change a stored setting start a write cycle;
	// while it runs, an address poll must go unanswered
	task automatic wait_idle(input logic nv);
		int n = 0;
		repeat (10) @(negedge clk_i);
		chk(busy === nv, "write cycle flag wrong");
		if (nv) begin
			u_qpot_host_model.start();
			u_qpot_host_model.send({TYPE, addr}, a);
			u_qpot_host_model.stop();
			chk(!a, "ack while writing");
		end
		while (busy !== 1'b0 && n < NVC) begin
			@(negedge clk_i);
			n++;
		end
		if (n == NVC) begin
			chk(1'b0, "write never ended");
			end_sim();
		end
	endtask
	// mode 0: no data, 1: write data byte, 2: read data byte into v
	task automatic frame(input logic [7:0] ins, input logic [7:0] d, input int mode);
		u_qpot_host_model.start();
		u_qpot_host_model.send({TYPE, addr}, a);
		chk(a, "no address ack");
		u_qpot_host_model.send(ins, a);
		chk(a, "no instruction ack");
		if (mode == 1)
			u_qpot_host_model.send(d, a);
		if (mode == 1)
			chk(a, "no data ack");
		if (mode == 2)
			u_qpot_host_model.recv(v);
		u_qpot_host_model.stop();
		wait_idle(ins[7:4] == 4'hc || ins[7:4] == 4'he || ins[7:4] == 4'h8);
	endtask
	task automatic wr_all();
		for (int p = 0; p < 4; p++) begin
			wp[p] = $random(seed) & 63;
			frame(8'ha0 | 8'(p), 8'(wp[p]), 1);
		end
		chk_wp();
	endtask
	task automatic step(input int p, input int s);
		logic d;
		frame(8'ha0 | 8'(p), 8'(s), 1);
		wp[p] = s;
		u_qpot_host_model.start();
		u_qpot_host_model.send({TYPE, addr}, a);
		u_qpot_host_model.send(8'h20 | 8'(p), a);
		chk(a, "no step ack");
		for (int i = 0; i < 12; i++) begin
			d = (i < 4) ? (s > 31) : 1'($random(seed));
			u_qpot_host_model.bit_io(d, a);
			wp[p] = d ? (wp[p] < 63 ? wp[p] + 1 : 63) : (wp[p] > 0 ? wp[p] - 1 : 0);
		end
		u_qpot_host_model.stop();
		wait_idle(1'b0);
		chk_wp();
	endtask
	initial begin
		addr = 4'($random(seed));
		repeat (20) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		chk_wp();
		wr_all();
		u_qpot_host_model.start();
		u_qpot_host_model.send({TYPE, addr ^ 4'h5}, a);
		u_qpot_host_model.stop();
		chk(!a, "ack on foreign address");
		st[1][2] = $random(seed) & 63;
		frame(8'hc9, 8'(st[1][2]), 1);
		frame(8'hb9, 8'h0, 2);
		chk(v === 8'(st[1][2]), "read mismatch");
		frame(8'hd9, 8'h0, 0);
		wp[1] = st[1][2];
		chk_wp();
		frame(8'h91, 8'h0, 2);
		chk(v === 8'(wp[1]), "wiper read mismatch");
		frame(8'he7, 8'h0, 0);
		st[3][1] = wp[3];
		frame(8'hb7, 8'h0, 2);
		chk(v === 8'(st[3][1]), "saved wiper mismatch");
		frame(8'h8c, 8'h0, 0);
		for (int p = 0; p < 4; p++)
			st[p][3] = wp[p];
		wr_all();
		frame(8'h1c, 8'h0, 0);
		for (int p = 0; p < 4; p++)
			wp[p] = st[p][3];
		chk_wp();
		step(0, 62);
		step(2, 1);
		end_sim();
	end
endmodule // tb
`default_nettype wire
